// File: rtl/rmt_timer_set.sv
// resettable millisecond timer set: pulse, on-delay, off-delay, accumulate
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rmt_timer_set #(
	parameter int unsigned N_INST = rmt_pkg::INST_MAX,
	parameter int unsigned CYCLES = rmt_pkg::CYCLES_PER_MS,
	parameter int unsigned IDX_W  = $clog2(N_INST)
) (
	input  wire logic              core_clk_i,   // system clock
	input  wire logic              rst_n_i,      // async reset, low
	input  wire logic              eval_i,       // evaluate one instance
	input  wire logic [IDX_W-1:0]  inst_i,       // instance index
	input  wire rmt_pkg::rmt_req_t req_i,        // mode, run, reset, preset
	output logic                   rsp_valid_o,  // answer strobe
	output rmt_pkg::rmt_rsp_t      rsp_o,        // done and elapsed
	output logic [31:0]            now_ms_o      // shared time base
);
	import rmt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// time base

	rmt_tick #(
		.CYCLES (CYCLES)
	) u_tick (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.now_ms_o   (now_ms_o)
	);

	////////////////////////////////////////////////////////////////////////
	// instance store
	// the record array carries no reset; a valid bit per instance marks
	// records that hold real history, so reset still yields fresh timers

	rmt_rec_t          mem [N_INST];
	logic [N_INST-1:0] vld;
	logic [N_INST-1:0] next_vld;
	rmt_rec_t          cur;
	rmt_rec_t          nrec;
	logic [TIME_W-1:0] plim;
	logic [TIME_W-1:0] seg;
	logic [TIME_W:0]   tot;
	logic [TIME_W-1:0] nel;
	logic              rise;
	logic              fall;
	logic              clr_rel;
	logic              next_rsp_valid;
	rmt_rsp_t          next_rsp;

	function automatic logic [TIME_W-1:0] clamp_preset(
		input logic signed [31:0] p
	);
		if (p <= 0)
			return ELAPSED_RST;
		return 32'(p) & PRESET_MAX;
	endfunction

	// a record left by another mode is treated as a fresh timer
	assign cur = (vld[inst_i] && mem[inst_i].mode == req_i.mode)
		? mem[inst_i] : rmt_rec_t'(0);
	assign plim    = clamp_preset(req_i.preset_limit);
	assign seg     = now_ms_o - cur.base;
	assign tot     = {1'b0, cur.acc} + {1'b0, seg};
	assign rise    = req_i.run && !cur.run_q;
	assign fall    = !req_i.run && cur.run_q;
	assign clr_rel = !req_i.clr && cur.clr_q;

	////////////////////////////////////////////////////////////////////////
	// per-mode evaluation

	always_comb begin
		nrec       = cur;
		nrec.mode  = req_i.mode;
		nrec.run_q = req_i.run;
		nrec.clr_q = req_i.clr;
		nel        = ELAPSED_RST;
		unique case (req_i.mode)
			PULSE_MODE: begin
				if (req_i.clr) begin
					nrec.flag   = cur.flag || cur.active;
					nrec.active = 1'b0;
					nrec.done   = 1'b0;
					nrec.acc    = ELAPSED_RST;
				end else if (!cur.active && req_i.run &&
						(rise || (clr_rel && cur.flag))) begin
					nrec.flag   = 1'b0;
					nrec.active = 1'b1;
					nrec.done   = 1'b1;
					nrec.base   = now_ms_o;
					nrec.acc    = ELAPSED_RST;
				end else if (cur.active) begin
					nrec.flag = 1'b0;
					// expiry seen only now, so done may lag by a scan
					if (seg >= plim) begin
						nrec.active = 1'b0;
						nrec.done   = 1'b0;
						nrec.acc    = plim;
					end else begin
						nrec.acc  = seg;
						nrec.done = 1'b1;
					end
				end else begin
					nrec.flag = 1'b0;
				end
				// held after expiry while run stays high
				nel = (nrec.active || req_i.run) ? nrec.acc
					: ELAPSED_RST;
			end
			ON_DELAY_MODE: begin
				if (req_i.clr) begin
					nrec.active = 1'b0;
					nrec.done   = 1'b0;
					nrec.acc    = ELAPSED_RST;
					nrec.flag   = req_i.run;
				end else if (!req_i.run) begin
					nrec.active = 1'b0;
					nrec.done   = 1'b0;
					nrec.acc    = ELAPSED_RST;
					nrec.flag   = 1'b0;
				end else if (rise && !cur.flag) begin
					// a zero preset is already reached at the start scan
					nrec.active = (plim != ELAPSED_RST);
					nrec.done   = (plim == ELAPSED_RST);
					nrec.base   = now_ms_o;
					nrec.acc    = ELAPSED_RST;
				end else if (cur.active) begin
					if (seg >= plim) begin
						nrec.active = 1'b0;
						nrec.done   = 1'b1;
						nrec.acc    = plim;
					end else begin
						nrec.acc = seg;
					end
				end
				nel = req_i.run ? nrec.acc : ELAPSED_RST;
			end
			OFF_DELAY_MODE: begin
				if (req_i.run) begin
					// reset only masks done while run is high
					nrec.done   = !req_i.clr;
					nrec.active = 1'b0;
					nrec.acc    = ELAPSED_RST;
				end else if (req_i.clr) begin
					nrec.done   = 1'b0;
					nrec.active = 1'b0;
					nrec.acc    = ELAPSED_RST;
				end else if (fall) begin
					// no new cycle without a fresh fall after reset
					nrec.active = 1'b1;
					nrec.done   = 1'b1;
					nrec.base   = now_ms_o;
					nrec.acc    = ELAPSED_RST;
				end else if (cur.active) begin
					if (seg >= plim) begin
						nrec.active = 1'b0;
						nrec.done   = 1'b0;
						nrec.acc    = plim;
					end else begin
						nrec.acc = seg;
					end
				end
				nel = nrec.acc;
			end
			ACCUMULATE_MODE: begin
				if (req_i.clr) begin
					nrec.active = 1'b0;
					nrec.done   = 1'b0;
					nrec.acc    = ELAPSED_RST;
				end else if (req_i.run || cur.active) begin
					// time between the last scan and a drop of run is
					// credited at the next scan; resolution is one scan
					if (cur.active)
						nrec.acc = (tot >= {1'b0, plim}) ? plim
							: tot[TIME_W-1:0];
					nrec.active = req_i.run;
					nrec.base   = now_ms_o;
					nrec.done   = (nrec.acc >= plim);
				end
				nel = nrec.acc;
			end
			default: begin
				nrec = cur;
				nel  = ELAPSED_RST;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// answer and bookkeeping

	always_comb begin
		next_vld       = vld;
		next_rsp       = rsp_o;
		next_rsp_valid = 1'b0;
		if (eval_i) begin
			next_vld[inst_i]       = 1'b1;
			next_rsp.done          = nrec.done;
			next_rsp.elapsed_count = nel;
			next_rsp_valid         = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vld         <= '0;
			rsp_o       <= '0;
			rsp_valid_o <= 1'b0;
		end else begin
			vld         <= next_vld;
			rsp_o       <= next_rsp;
			rsp_valid_o <= next_rsp_valid;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (eval_i)
			mem[inst_i] <= nrec;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_answer_next_cycle: assert property (
		eval_i |=> rsp_valid_o ##1 (!rsp_valid_o || $past(eval_i))
	) else $error("answer not one cycle after evaluation");

	a_time_base_step: assert property (
		$changed(now_ms_o) |-> now_ms_o == $past(now_ms_o) + 32'h00000001
			##1 $stable(now_ms_o)
	) else $error("time base did not step by one");

	a_outputs_only_eval: assert property (
		!$past(eval_i) |-> $stable(rsp_o)
	) else $error("outputs changed without evaluation");

	a_elapsed_bounded: assert property (
		eval_i |=> rsp_o.elapsed_count <= $past(plim)
	) else $error("elapsed above clamped preset");

	a_pulse_start: assert property (
		eval_i && req_i.mode == PULSE_MODE && rise && !req_i.clr
			&& !cur.active |=> rsp_o.done
	) else $error("pulse did not raise done on run rise");

	a_ondelay_drop: assert property (
		eval_i && req_i.mode == ON_DELAY_MODE && !req_i.run
			|=> !rsp_o.done && rsp_o.elapsed_count == ELAPSED_RST
	) else $error("on-delay not cleared with run low");

	a_offdelay_run_high: assert property (
		eval_i && req_i.mode == OFF_DELAY_MODE && req_i.run
			|=> rsp_o.elapsed_count == ELAPSED_RST
			&& rsp_o.done == !$past(req_i.clr)
	) else $error("off-delay wrong while run high");

	a_reset_clears: assert property (
		eval_i && req_i.clr && !(req_i.mode == OFF_DELAY_MODE && req_i.run)
			|=> !rsp_o.done && rsp_o.elapsed_count == ELAPSED_RST
	) else $error("timer reset did not clear");

	a_accum_hold: assert property (
		eval_i && req_i.mode == ACCUMULATE_MODE && !req_i.run
			&& !req_i.clr && !cur.active
			|=> rsp_o.elapsed_count == $past(cur.acc)
	) else $error("accumulated value changed while idle");

	a_ondelay_fresh_edge: assert property (
		eval_i && req_i.mode == ON_DELAY_MODE && req_i.run && !req_i.clr
			&& cur.flag |=> !rsp_o.done
	) else $error("on-delay restarted without fresh run edge");

	a_ondelay_zero_preset: assert property (
		eval_i && req_i.mode == ON_DELAY_MODE && rise && !req_i.clr
			&& !cur.flag && plim == ELAPSED_RST |=> rsp_o.done
	) else $error("on-delay with zero preset not done at start");

endmodule // rmt_timer_set

`default_nettype wire

// File: rtl/rmt_pkg.sv
// shared constants and carrier types of the resettable millisecond timer set
`default_nettype none

package rmt_pkg;

	localparam int unsigned TIME_W        = 32;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_NS       = 1_000_000;
	localparam int unsigned CYCLES_PER_MS = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned INST_MAX      = 4096;
	localparam logic [TIME_W-1:0] PRESET_MAX  = 32'h7FFFFFFF;
	localparam logic [TIME_W-1:0] ELAPSED_RST = 32'h00000000;
	localparam logic [TIME_W-1:0] NOW_RST     = 32'h00000000;

	typedef enum logic [3:0] {
		PULSE_MODE      = 4'b0001,
		ON_DELAY_MODE   = 4'b0010,
		OFF_DELAY_MODE  = 4'b0100,
		ACCUMULATE_MODE = 4'b1000
	} rmt_mode_t;

	// one evaluation request from the controller program
	typedef struct packed {
		rmt_mode_t          mode;
		logic               run;
		logic               clr;
		logic signed [31:0] preset_limit;
	} rmt_req_t;

	// answer of one evaluation
	typedef struct packed {
		logic              done;
		logic [TIME_W-1:0] elapsed_count;
	} rmt_rsp_t;

	// per-instance memory record
	typedef struct packed {
		rmt_mode_t         mode;
		logic              active;
		logic              done;
		logic              run_q;
		logic              clr_q;
		logic              flag;
		logic [TIME_W-1:0] base;
		logic [TIME_W-1:0] acc;
	} rmt_rec_t;

endpackage : rmt_pkg

`default_nettype wire

// File: rtl/rmt_tick.sv
// free-running millisecond time base
`default_nettype none

module rmt_tick #(
	parameter int unsigned CYCLES = rmt_pkg::CYCLES_PER_MS
) (
	input  wire logic                       core_clk_i, // system clock
	input  wire logic                       rst_n_i,    // async reset, low
	output logic [rmt_pkg::TIME_W-1:0]      now_ms_o    // ms since reset
);
	import rmt_pkg::*;

	logic [31:0]       div;
	logic [31:0]       next_div;
	logic [TIME_W-1:0] next_now;

	always_comb begin
		next_div = div + 32'h00000001;
		next_now = now_ms_o;
		if (div >= 32'(CYCLES - 1)) begin
			next_div = 32'h00000000;
			next_now = now_ms_o + 32'h00000001;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div      <= 32'h00000000;
			now_ms_o <= NOW_RST;
		end else begin
			div      <= next_div;
			now_ms_o <= next_now;
		end
	end

endmodule // rmt_tick

`default_nettype wire

// File: tb/rmt_ctrl_model.sv
// controller-program model that evaluates timer instances once per scan
`default_nettype none

module rmt_ctrl_model
	import rmt_pkg::*;
#(
	parameter int unsigned CYCLES = 4,
	parameter int unsigned IDX_W  = 3
) (
	input  wire logic              core_clk_i,  // system clock
	input  wire logic              rsp_valid_i, // answer strobe
	input  wire rmt_pkg::rmt_rsp_t rsp_i,       // done and elapsed
	output logic                   eval_o,      // evaluate strobe
	output logic [IDX_W-1:0]       inst_o,      // instance index
	output rmt_pkg::rmt_req_t      req_o        // evaluation request
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		eval_o = 1'h0;
		inst_o = '0;
		req_o  = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// taken edges lie gap*CYCLES apart, so elapsed is whole ms
	task automatic scan(input int gap, input logic [IDX_W-1:0] idx,
		input rmt_req_t rq, output rmt_rsp_t rsp, output logic seen);
		repeat (gap * CYCLES - 2) @(posedge core_clk_i);
		eval_o <= 1'h1;
		inst_o <= idx;
		req_o  <= rq;
		@(posedge core_clk_i);
		eval_o <= 1'h0;
		// inputs change between scans; only the strobed cycle may count
		inst_o <= ~idx;
		req_o  <= ~rq;
		@(posedge core_clk_i);
		seen = rsp_valid_i;
		rsp  = rsp_i;
	endtask

endmodule // rmt_ctrl_model

`default_nettype wire

// File: tb/rmt_timer_set_tb_top.sv
// self-checking bench of the timer set, scan by scan
`default_nettype none

module rmt_timer_set_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rmt_pkg::*;

	localparam int unsigned CYC = 4;
	localparam int unsigned NI  = 8;

	logic               core_clk;
	logic               rst_n;
	logic               eval;
	logic [2:0]         inst;
	rmt_req_t           req;
	logic               rsp_valid;
	rmt_rsp_t           rsp;
	logic [31:0]        now_ms;
	int                 err_total;
	int                 tests_run;
	int                 seed;
	int                 sum;
	int                 g;
	int                 p;
	rmt_mode_t          cur_mode;
	logic [2:0]         cur_inst;
	logic signed [31:0] cur_pre;
	logic [31:0]        t0;

	rmt_timer_set #(.N_INST(NI), .CYCLES(CYC)) u_rmt_timer_set (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .eval_i(eval),
		.inst_i(inst), .req_i(req), .rsp_valid_o(rsp_valid),
		.rsp_o(rsp), .now_ms_o(now_ms));

	rmt_ctrl_model #(.CYCLES(CYC), .IDX_W(3)) u_rmt_ctrl_model (
		.core_clk_i(core_clk), .rsp_valid_i(rsp_valid), .rsp_i(rsp),
		.eval_o(eval), .inst_o(inst), .req_o(req));

	initial core_clk = 1'h0;
	always #5 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////
	function automatic int exp_el(input int s, input int lim);
		return (s >= lim) ? lim : s;
	endfunction

	task automatic chk_bit(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %0b seen %0b", what, exp, got);
		end
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic open(input rmt_mode_t m, input logic [2:0] i, input int pr);
		cur_mode = m;
		cur_inst = i;
		cur_pre  = pr;
	endtask

	task automatic close(input string name);
		$display("test %s finished, mismatches %0d", name, err_total);
	endtask

	// one scan: evaluate, then compare strobe, done and elapsed
	task automatic step(input int gap, input int run, input int clr,
		input int done, input int el);
		rmt_req_t rq;
		rmt_rsp_t rs;
		logic     seen;
		rq.mode         = cur_mode;
		rq.run          = 1'(run);
		rq.clr          = 1'(clr);
		rq.preset_limit = cur_pre;
		u_rmt_ctrl_model.scan(gap, cur_inst, rq, rs, seen);
		chk_bit("answer strobe", 1'h1, seen);
		chk_bit("done", 1'(done), rs.done);
		chk_word("elapsed", 32'(el), rs.elapsed_count);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		print_verdict();
	end

	initial begin
		err_total = 0;
		tests_run = 0;
		seed      = 32'h559F;
		rst_n     = 1'h0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		open(PULSE_MODE, 3'h1, 3);
		step(1, 1, 0, 1, 0);
		step(1, 0, 0, 1, 1);
		step(2, 0, 0, 0, 0);
		step(1, 1, 0, 1, 0);
		step(1, 1, 1, 0, 0);
		step(2, 1, 0, 1, 0);
		step(1, 1, 0, 1, 1);
		open(PULSE_MODE, 3'h2, 3);
		step(1, 1, 0, 1, 0);
		step(3, 1, 0, 0, 3);
		close("pulse");
		open(ON_DELAY_MODE, 3'h3, 2);
		step(1, 1, 0, 0, 0);
		step(1, 1, 0, 0, 1);
		step(1, 1, 0, 1, 2);
		step(2, 1, 0, 1, 2);
		step(1, 0, 0, 0, 0);
		step(1, 1, 0, 0, 0);
		step(1, 1, 1, 0, 0);
		step(1, 1, 0, 0, 0);
		step(3, 1, 0, 0, 0);
		step(1, 0, 0, 0, 0);
		step(1, 1, 0, 0, 0);
		step(2, 1, 0, 1, 2);
		open(ON_DELAY_MODE, 3'h0, -5);
		step(1, 1, 0, 1, 0);
		step(2, 1, 0, 1, 0);
		close("on_delay");
		open(OFF_DELAY_MODE, 3'h4, 2);
		step(1, 1, 0, 1, 0);
		step(1, 1, 1, 0, 0);
		step(1, 1, 0, 1, 0);
		step(1, 0, 0, 1, 0);
		step(1, 0, 0, 1, 1);
		step(1, 0, 0, 0, 2);
		step(2, 0, 0, 0, 2);
		step(1, 1, 0, 1, 0);
		step(1, 0, 0, 1, 0);
		step(1, 0, 1, 0, 0);
		step(1, 0, 0, 0, 0);
		step(2, 0, 0, 0, 0);
		close("off_delay");
		open(ACCUMULATE_MODE, 3'h7, 3);
		step(1, 1, 0, 0, 0);
		step(1, 1, 0, 0, 1);
		step(1, 0, 0, 0, 2);
		step(2, 0, 0, 0, 2);
		step(1, 1, 0, 0, 2);
		step(1, 1, 0, 1, 3);
		step(2, 1, 0, 1, 3);
		step(1, 0, 1, 0, 0);
		step(1, 0, 0, 0, 0);
		step(1, 1, 0, 0, 0);
		step(1, 1, 0, 0, 1);
		open(ON_DELAY_MODE, 3'h3, 2);
		step(1, 1, 0, 1, 2);
		close("accumulate");
		// an unknown mode code still answers, with a cleared result
		open(rmt_mode_t'(4'h0), 3'h6, 2);
		step(1, 1, 0, 0, 0);
		close("illegal_mode");
		for (int k = 0; k < 6; k++) begin
			sum = 0;
			p = 1 + int'($unsigned($random(seed)) % 4);
			open(ON_DELAY_MODE, 3'(5 + k % 3), p);
			step(1, 0, 0, 0, 0);
			step(1, 1, 0, 0, 0);
			while (sum <= p) begin
				g = 1 + int'($unsigned($random(seed)) % 2);
				sum += g;
				step(g, 1, 0, int'(sum >= p), exp_el(sum, p));
			end
		end
		close("random");
		t0 = now_ms;
		repeat (5 * CYC) @(posedge core_clk);
		chk_word("time base", t0 + 32'h00000005, now_ms);
		close("time_base");
		print_verdict();
	end

endmodule // rmt_timer_set_tb_top

`default_nettype wire
